// file: design/timer_wave_regs.svh
// constants of the 8-bit timer waveform generator
`ifndef TIMER_WAVE_REGS_SVH
`define TIMER_WAVE_REGS_SVH
`define MODE_NORMAL 3'h0
`define MODE_PC_FULL 3'h1
`define MODE_CTC 3'h2
`define MODE_FAST_FULL 3'h3
`define MODE_PC_VAR 3'h5
`define MODE_FAST_VAR 3'h7
`define MODE_UPPER_BIT 2
`define ACT_OFF 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3
`define COUNT_BOTTOM 8'h00
`define COUNT_MAX 8'hFF
`define COUNT_STEP 8'h01
`define COUNT_RESET 8'h00
`define WAVE_RESET 1'b0
`define FLAG_OVF 0
`define FLAG_CMP_A 1
`define FLAG_CMP_B 2
`define FAST_PERIOD 10'h100
`define PC_PERIOD 10'h1FE
`endif

// file: design/timer_wave_pkg.sv
// types shared by the timer waveform generator
package timer_wave_pkg;
  typedef logic [7:0] count_type;
  typedef logic [2:0] mode_type;
  typedef logic [1:0] action_type;
  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } dir_type;
endpackage

// file: design/timer_link_if.sv
// counter state handed from the counter to the compare channels
interface timer_link_if;
  import timer_wave_pkg::*;
  logic tick;
  count_type count;
  count_type top;
  logic down;
  logic at_top;
  logic at_bottom;
  logic is_ctc;
  logic is_fast;
  logic is_pc;
  logic mode_upper;
  logic blocked;
  modport source (output tick, count, top, down, at_top, at_bottom, is_ctc, is_fast, is_pc,
    mode_upper, blocked);
  modport sink (input tick, count, top, down, at_top, at_bottom, is_ctc, is_fast, is_pc,
    mode_upper, blocked);
endinterface

// file: design/compare_buffer.sv
// compare value with its pwm double buffer
`include "timer_wave_regs.svh"
module compare_buffer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // counter state
  timer_link_if.sink link,
  // software write
  input wire logic write,
  input wire timer_wave_pkg::count_type write_data,
  // values
  output timer_wave_pkg::count_type buffer_value,
  output timer_wave_pkg::count_type active_value
);
  import timer_wave_pkg::*;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      buffer_value <= `COUNT_RESET;
    end else if (write) begin
      buffer_value <= write_data;
    end
  end

  // pwm reloads only at the turn point so no odd-length pulse appears
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      active_value <= `COUNT_RESET;
    end else if (!(link.is_fast || link.is_pc)) begin
      if (write) begin
        active_value <= write_data;
      end
    end else if (link.tick && link.at_top) begin
      active_value <= buffer_value;
    end
  end

  property p_buffered;
    @(posedge sys_clk) disable iff (!rst_n)
    (link.is_fast || link.is_pc) && write && !(link.tick && link.at_top)
      |=> active_value == $past(active_value);
  endproperty
  a_buffered: assert property (p_buffered) else $error("pwm compare write took effect early");

  property p_direct;
    @(posedge sys_clk) disable iff (!rst_n)
    link.is_ctc && write |=> active_value == $past(write_data);
  endproperty
  a_direct: assert property (p_direct) else $error("ctc compare write not direct");
endmodule // compare_buffer

// file: design/wave_unit.sv
// compare match detection and output waveform for one channel
`include "timer_wave_regs.svh"
module wave_unit #(
  parameter bit HAS_TOGGLE = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // counter state
  timer_link_if.sink link,
  // channel control
  input wire timer_wave_pkg::count_type compare,
  input wire timer_wave_pkg::action_type action,
  input wire logic force_match,
  // results
  output logic match_tick,
  output logic wave
);
  import timer_wave_pkg::*;

  logic match;
  logic up_seen;
  logic next_wave;
  logic pwm_toggle;
  logic match_level;

  assign match = (link.count == compare) && !link.blocked;
  assign match_tick = link.tick && match;
  assign pwm_toggle = HAS_TOGGLE && link.mode_upper && (action == `ACT_TOGGLE);
  // a bottom compare counts as up-match so the output stays flat
  assign match_level = (link.down && compare != `COUNT_BOTTOM) ? ~action[0] : action[0];

  always_comb begin
    next_wave = wave;
    if (link.is_fast || link.is_pc) begin
      if (pwm_toggle) begin
        if (match_tick) begin
          next_wave = ~wave;
        end
      end else if (action[1] && link.tick) begin
        if (link.is_fast) begin
          if (match && compare != link.top) begin
            next_wave = action[0];
          end
          if (link.at_top) begin
            next_wave = ~action[0];
          end
        end else if (match && compare != link.top) begin
          next_wave = match_level;
        end else if (link.at_top && !link.down) begin
          if (compare == link.top) begin
            next_wave = ~action[0];
          end else if (!up_seen) begin
            next_wave = action[0];
          end
        end
      end
    end else if (match_tick || force_match) begin
      case (action)
        `ACT_TOGGLE: next_wave = ~wave;
        `ACT_CLEAR: next_wave = 1'b0;
        `ACT_SET: next_wave = 1'b1;
        default: next_wave = wave;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wave <= `WAVE_RESET;
    end else begin
      wave <= next_wave;
    end
  end

  // remembers the up-slope match so a missed one is made good at top
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      up_seen <= 1'b0;
    end else if (match_tick && (!link.down || compare == `COUNT_BOTTOM)) begin
      up_seen <= 1'b1;
    end else if (link.tick && link.at_bottom && link.down) begin
      up_seen <= 1'b0;
    end
  end

  property p_toggle;
    @(posedge sys_clk) disable iff (!rst_n)
    link.is_ctc && match_tick && action == `ACT_TOGGLE |=> wave != $past(wave);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle on match missing");

  property p_fast_bottom;
    @(posedge sys_clk) disable iff (!rst_n)
    link.is_fast && link.tick && link.at_top && action[1] |=> wave == !$past(action[0]);
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("fast pwm bottom level wrong");
endmodule // wave_unit

// file: design/timer_wave_top.sv
// 8-bit timer counter with clear-on-match, fast pwm and phase correct pwm
`include "timer_wave_regs.svh"
module timer_wave_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // prescaled timer clock enable
  input wire logic timer_tick,
  // configuration
  input wire timer_wave_pkg::mode_type waveform_mode_field,
  input wire timer_wave_pkg::action_type output_a_action_bits,
  input wire timer_wave_pkg::action_type output_b_action_bits,
  // software writes
  input wire logic compare_a_write,
  input wire logic compare_b_write,
  input wire timer_wave_pkg::count_type compare_write_data,
  input wire logic count_write,
  input wire timer_wave_pkg::count_type count_write_data,
  input wire logic force_a,
  input wire logic force_b,
  input wire logic [2:0] flag_clear,
  // state readback
  output timer_wave_pkg::count_type count_value,
  output timer_wave_pkg::count_type compare_value_a,
  output timer_wave_pkg::count_type compare_value_b,
  output logic overflow_flag,
  output logic compare_flag_a,
  output logic compare_flag_b,
  // compare output pins
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_out_a_en,
  output logic wave_out_b_en
);
  import timer_wave_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  timer_link_if link ();

  logic is_ctc;
  logic is_fast;
  logic is_pc;
  logic top_from_compare;
  count_type top;
  count_type next_count;
  dir_type dir;
  dir_type next_dir;
  logic blocked;
  logic ovf_event;
  logic [2:0] flag_set;
  logic [1:0] pending;
  logic [9:0] period_ticks;
  logic period_valid;

  count_type active [2];
  count_type shown [2];
  logic ch_write [2];
  action_type ch_action [2];
  logic ch_force [2];
  logic ch_match [2];
  logic ch_wave [2];
  logic ch_en [2];

  assign is_ctc = waveform_mode_field == `MODE_CTC;
  assign is_fast = waveform_mode_field == `MODE_FAST_FULL ||
    waveform_mode_field == `MODE_FAST_VAR;
  assign is_pc = waveform_mode_field == `MODE_PC_FULL ||
    waveform_mode_field == `MODE_PC_VAR;
  assign top_from_compare = is_ctc || waveform_mode_field == `MODE_FAST_VAR ||
    waveform_mode_field == `MODE_PC_VAR;
  assign top = top_from_compare ? active[0] : `COUNT_MAX;

  assign link.tick = timer_tick;
  assign link.count = count_value;
  assign link.top = top;
  assign link.down = dir == DIR_DOWN;
  assign link.at_top = count_value == top;
  assign link.at_bottom = count_value == `COUNT_BOTTOM;
  assign link.is_ctc = is_ctc;
  assign link.is_fast = is_fast;
  assign link.is_pc = is_pc;
  assign link.mode_upper = waveform_mode_field[`MODE_UPPER_BIT];
  assign link.blocked = blocked;

  ////////////////////////////////////////////////////////////////////////////
  // counting sequence

  always_comb begin
    next_count = count_value;
    next_dir = is_pc ? dir : DIR_UP;
    if (count_write) begin
      next_count = count_write_data;
    end else if (timer_tick) begin
      if (is_ctc || is_fast) begin
        // a top below the count is missed and the count wraps through MAX
        next_count = link.at_top ? `COUNT_BOTTOM : count_value + `COUNT_STEP;
      end else if (is_pc) begin
        if (dir == DIR_UP) begin
          if (link.at_top) begin
            next_dir = DIR_DOWN;
            next_count = (top == `COUNT_BOTTOM) ? `COUNT_BOTTOM : count_value - `COUNT_STEP;
          end else begin
            next_count = count_value + `COUNT_STEP;
          end
        end else if (link.at_bottom) begin
          next_dir = DIR_UP;
          next_count = (top == `COUNT_BOTTOM) ? `COUNT_BOTTOM : count_value + `COUNT_STEP;
        end else begin
          next_count = count_value - `COUNT_STEP;
        end
      end else begin
        next_count = count_value + `COUNT_STEP;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_value <= `COUNT_RESET;
    end else begin
      count_value <= next_count;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dir <= DIR_UP;
    end else begin
      case (next_dir)
        DIR_UP: dir <= DIR_UP;
        DIR_DOWN: dir <= DIR_DOWN;
        default: dir <= DIR_UP;
      endcase
    end
  end

  // holds until the next tick, so a stopped timer still blocks one match
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      blocked <= 1'b0;
    end else if (count_write) begin
      blocked <= 1'b1;
    end else if (timer_tick) begin
      blocked <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare channels

  assign ch_write[0] = compare_a_write;
  assign ch_write[1] = compare_b_write;
  assign ch_action[0] = output_a_action_bits;
  assign ch_action[1] = output_b_action_bits;
  assign ch_force[0] = force_a && !(is_fast || is_pc);
  assign ch_force[1] = force_b && !(is_fast || is_pc);

  for (genvar i = 0; i < 2; i++) begin : g_channel
    compare_buffer u_buffer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .link(link.sink),
      .write(ch_write[i]),
      .write_data(compare_write_data),
      .buffer_value(shown[i]),
      .active_value(active[i])
    );

    wave_unit #(.HAS_TOGGLE(i == 0)) u_wave (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .link(link.sink),
      .compare(active[i]),
      .action(ch_action[i]),
      .force_match(ch_force[i]),
      .match_tick(ch_match[i]),
      .wave(ch_wave[i])
    );

    // pin override; the port direction stays with software
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        ch_en[i] <= 1'b0;
      end else begin
        ch_en[i] <= ch_action[i][1] || (ch_action[i] == `ACT_TOGGLE &&
          (!(is_fast || is_pc) || (i == 0 && link.mode_upper)));
      end
    end

    // flag lands one tick after the match
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        pending[i] <= 1'b0;
      end else if (timer_tick) begin
        pending[i] <= ch_match[i];
      end
    end
  end

  assign compare_value_a = shown[0];
  assign compare_value_b = shown[1];
  assign wave_out_a = ch_wave[0];
  assign wave_out_b = ch_wave[1];
  assign wave_out_a_en = ch_en[0];
  assign wave_out_b_en = ch_en[1];

  ////////////////////////////////////////////////////////////////////////////
  // flags

  assign ovf_event = timer_tick && !count_write && (
    (is_fast && link.at_top) ||
    (is_pc && link.at_bottom) ||
    (!is_fast && !is_pc && count_value == `COUNT_MAX));
  assign flag_set[`FLAG_OVF] = ovf_event;
  assign flag_set[`FLAG_CMP_A] = timer_tick && pending[0];
  assign flag_set[`FLAG_CMP_B] = timer_tick && pending[1];

  // a set in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= flag_set[`FLAG_OVF] || (overflow_flag && !flag_clear[`FLAG_OVF]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      compare_flag_a <= 1'b0;
    end else begin
      compare_flag_a <= flag_set[`FLAG_CMP_A] ||
        (compare_flag_a && !flag_clear[`FLAG_CMP_A]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      compare_flag_b <= 1'b0;
    end else begin
      compare_flag_b <= flag_set[`FLAG_CMP_B] ||
        (compare_flag_b && !flag_clear[`FLAG_CMP_B]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // ticks between overflow events, only for the period checks
  always_ff @(posedge sys_clk) begin
    if (!rst_n || count_write) begin
      period_ticks <= 10'h000;
      period_valid <= 1'b0;
    end else if (ovf_event) begin
      period_ticks <= 10'h001;
      period_valid <= 1'b1;
    end else if (timer_tick) begin
      period_ticks <= period_ticks + 10'h001;
    end
  end

  property p_ctc_clear;
    @(posedge sys_clk) disable iff (!rst_n)
    timer_tick && is_ctc && count_value == active[0] && !count_write
      |=> count_value == `COUNT_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc count not cleared");

  property p_ctc_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    timer_tick && is_ctc && count_value == `COUNT_MAX && !count_write
      |=> count_value == `COUNT_BOTTOM && overflow_flag;
  endproperty
  a_ctc_wrap: assert property (p_ctc_wrap) else $error("ctc wrap or overflow wrong");

  property p_fast_step;
    @(posedge sys_clk) disable iff (!rst_n)
    timer_tick && is_fast && !link.at_top && !count_write
      |=> count_value == $past(count_value) + `COUNT_STEP;
  endproperty
  a_fast_step: assert property (p_fast_step) else $error("fast pwm count not rising");

  property p_fast_restart;
    @(posedge sys_clk) disable iff (!rst_n)
    timer_tick && is_fast && link.at_top && !count_write
      |=> count_value == `COUNT_BOTTOM && overflow_flag;
  endproperty
  a_fast_restart: assert property (p_fast_restart) else $error("fast pwm top wrong");

  property p_pc_turn;
    @(posedge sys_clk) disable iff (!rst_n)
    timer_tick && is_pc && dir == DIR_UP && link.at_top && top != `COUNT_BOTTOM &&
      !count_write |=> count_value == $past(top) - `COUNT_STEP && dir == DIR_DOWN;
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("phase correct top not single");

  property p_pc_ovf;
    @(posedge sys_clk) disable iff (!rst_n)
    timer_tick && is_pc && link.at_bottom && !count_write |=> overflow_flag;
  endproperty
  a_pc_ovf: assert property (p_pc_ovf) else $error("phase correct overflow missing");

  property p_flag_delay;
    @(posedge sys_clk) disable iff (!rst_n)
    ch_match[0] ##1 timer_tick
      |=> compare_flag_a;
  endproperty
  a_flag_delay: assert property (p_flag_delay) else $error("compare flag not set");

  property p_block;
    @(posedge sys_clk) disable iff (!rst_n)
    count_write ##1 timer_tick |-> !ch_match[0] && !ch_match[1];
  endproperty
  a_block: assert property (p_block) else $error("match after count write");

  property p_hold_no_tick;
    @(posedge sys_clk) disable iff (!rst_n)
    !timer_tick && !count_write |=> count_value == $past(count_value);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick) else $error("count moved without tick");

  property p_period;
    @(posedge sys_clk) disable iff (!rst_n)
    ovf_event && period_valid && $stable(waveform_mode_field) &&
      (waveform_mode_field == `MODE_FAST_FULL || waveform_mode_field == `MODE_PC_FULL)
      |-> period_ticks == (is_fast ? `FAST_PERIOD : `PC_PERIOD);
  endproperty
  a_period: assert property (p_period) else $error("pwm period length wrong");
endmodule // timer_wave_top

// file: dv/wave_pin_load.sv
// port pin load model fed by one compare output
module wave_pin_load (
  // timer side
  input wire logic wave,
  input wire logic wave_en,
  // port control
  input wire logic dir_out,
  input wire logic port_level,
  // pad as seen by the external load
  output logic pin
);
  // an input pin is not driven, so the load sees the pull-down level
  assign pin = dir_out ? (wave_en ? wave : port_level) : 1'b0;
endmodule // wave_pin_load

// file: dv/timer_waveform_modes_8bit_tb_top.sv
// self-checking bench for the 8-bit timer waveform generator
`include "timer_wave_regs.svh"
module timer_waveform_modes_8bit_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import timer_wave_pkg::*;
  logic sys_clk, rst_n, timer_tick, compare_a_write, compare_b_write, count_write;
  logic force_a, force_b, dir_out, port_level, pin_a, overflow_flag, compare_flag_a;
  logic compare_flag_b, wave_out_a, wave_out_b, wave_out_a_en, wave_out_b_en;
  logic [2:0] flag_clear;
  mode_type mode;
  action_type act_a, act_b;
  count_type wdata, count_value, compare_value_a, compare_value_b;
  int err_count, check_count;
  ////////////////////////////////////////
  timer_wave_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .timer_tick(timer_tick),
    .waveform_mode_field(mode), .output_a_action_bits(act_a), .output_b_action_bits(act_b),
    .compare_a_write(compare_a_write), .compare_b_write(compare_b_write),
    .compare_write_data(wdata), .count_write(count_write), .count_write_data(wdata),
    .force_a(force_a), .force_b(force_b), .flag_clear(flag_clear),
    .count_value(count_value), .compare_value_a(compare_value_a),
    .compare_value_b(compare_value_b), .overflow_flag(overflow_flag),
    .compare_flag_a(compare_flag_a), .compare_flag_b(compare_flag_b),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .wave_out_a_en(wave_out_a_en),
    .wave_out_b_en(wave_out_b_en));
  wave_pin_load pin_load (.wave(wave_out_a), .wave_en(wave_out_a_en), .dir_out(dir_out),
    .port_level(port_level), .pin(pin_a));
  ////////////////////////////////////////
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic cfg(input mode_type m, input action_type a, input action_type b, input logic t);
    @(posedge sys_clk);
    mode <= m;
    act_a <= a;
    act_b <= b;
    timer_tick <= t;
  endtask
  // sel bits: 0 compare a, 1 compare b, 2 count
  task automatic wr(input logic [2:0] sel, input count_type d);
    @(posedge sys_clk);
    {count_write, compare_b_write, compare_a_write} <= sel;
    wdata <= d;
    @(posedge sys_clk);
    {count_write, compare_b_write, compare_a_write} <= 3'h0;
  endtask
  task automatic reset_dut();
    cfg(`MODE_NORMAL, `ACT_OFF, `ACT_OFF, 1'b0);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
  endtask
  task automatic wait_cnt(input count_type v);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (count_value !== v && k < 1200);
    chk(10'(k < 1200), 10'h1);
  endtask
  // cycles until output a changes level, bounded
  task automatic flip(output int k);
    logic w;
    w = wave_out_a;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (wave_out_a === w && k < 40);
  endtask
  ////////////////////////////////////////
  task automatic t_hold();
    reset_dut();
    cyc(1);
    #1;
    chk({count_value, wave_out_a, wave_out_b}, 10'h0);
    chk(10'({overflow_flag, compare_flag_a, compare_flag_b}), 10'h0);
    cyc(20);
    #1;
    chk(10'(count_value), 10'h0);
    cfg(`MODE_NORMAL, `ACT_OFF, `ACT_OFF, 1'b1);
    cyc(3);
    #1;
    chk(10'(count_value), 10'h3);
    $display("test hold done");
  endtask
  task automatic t_ctc();
    int k;
    for (int c = 0; c < 4; c += 3) begin
      reset_dut();
      wr(3'h1, 8'(c));
      cfg(`MODE_CTC, `ACT_TOGGLE, `ACT_OFF, 1'b1);
      wait_cnt(8'(c));
      cyc(1);
      #1;
      chk(10'(count_value), 10'h0);
      flip(k);
      flip(k);
      chk(10'(k), 10'(c + 1));
      chk(10'(compare_flag_a), 10'h1);
    end
    $display("test ctc done");
  endtask
  task automatic t_late();
    reset_dut();
    wr(3'h1, 8'h80);
    cfg(`MODE_CTC, `ACT_OFF, `ACT_OFF, 1'b1);
    wait_cnt(8'h20);
    wr(3'h1, 8'h10);
    wait_cnt(8'h00);
    chk(10'({overflow_flag, compare_flag_a}), 10'h2);
    wait_cnt(8'h10);
    cyc(1);
    #1;
    chk(10'(count_value), 10'h0);
    cyc(1);
    #1;
    chk(10'(compare_flag_a), 10'h1);
    // stop the timer so only the clear pulse acts on the flags
    @(posedge sys_clk);
    timer_tick <= 1'b0;
    flag_clear <= 3'h3;
    @(posedge sys_clk);
    flag_clear <= 3'h0;
    #1;
    chk(10'({overflow_flag, compare_flag_a}), 10'h0);
    $display("test late write done");
  endtask
  task automatic t_block();
    reset_dut();
    wr(3'h1, 8'h10);
    cfg(`MODE_CTC, `ACT_SET, `ACT_OFF, 1'b0);
    wr(3'h4, 8'h10);
    timer_tick <= 1'b1;
    cyc(1);
    timer_tick <= 1'b0;
    cyc(3);
    #1;
    chk(10'({compare_flag_a, wave_out_a}), 10'h0);
    $display("test block done");
  endtask
  task automatic t_force();
    logic [2:0] seq [5] = '{3'h7, 3'h4, 3'h3, 3'h2, 3'h7};
    reset_dut();
    dir_out <= 1'b0;
    port_level <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      act_a <= seq[i][2:1];
      force_a <= 1'b1;
      @(posedge sys_clk);
      force_a <= 1'b0;
      #1;
      chk(10'({wave_out_a_en, wave_out_a}), 10'({1'b1, seq[i][0]}));
    end
    chk(10'(pin_a), 10'h0);
    @(posedge sys_clk);
    dir_out <= 1'b1;
    #1;
    chk(10'(pin_a), 10'h1);
    @(posedge sys_clk);
    act_a <= `ACT_OFF;
    cyc(1);
    #1;
    chk(10'({wave_out_a_en, pin_a}), 10'h0);
    $display("test force done");
  endtask
  task automatic t_duty();
    int ha, hb;
    logic [9:0] bexp;
    // mode, compare a, compare b, action a, action b, window, highs a, highs b
    int tab [8][8] = '{'{3, 'h40, 'h80, 2, 3, 256, 65, 127}, '{3, 0, 'hFF, 2, 3, 256, 1, 0},
      '{3, 'hFF, 'h10, 2, 1, 256, 256, 0}, '{7, 9, 3, 1, 2, 20, 10, 8},
      '{1, 'h40, 'h80, 2, 3, 510, 128, 254}, '{1, 0, 'hFF, 2, 3, 510, 0, 0},
      '{1, 'hFF, 0, 2, 3, 510, 510, 510}, '{5, 9, 3, 1, 2, 36, 18, 12}};
    for (int i = 0; i < 8; i++) begin
      reset_dut();
      wr(3'h1, 8'(tab[i][1]));
      wr(3'h2, 8'(tab[i][2]));
      cfg(3'(tab[i][0]), 2'(tab[i][3]), 2'(tab[i][4]), 1'b1);
      cyc(2 * tab[i][5] + 20);
      ha = 0;
      hb = 0;
      repeat (tab[i][5]) begin
        @(posedge sys_clk);
        #1;
        ha += int'(wave_out_a);
        hb += int'(wave_out_b);
      end
      chk(10'(ha), 10'(tab[i][6]));
      chk(10'(hb), 10'(tab[i][7]));
      chk(10'(overflow_flag), 10'h1);
      // channel b has no pwm toggle option, so action 1 leaves its pin disconnected
      bexp = {1'b1, tab[i][4] > 1, 8'(tab[i][2])};
      chk({compare_flag_b, wave_out_b_en, compare_value_b}, bexp);
    end
    $display("test duty done");
  endtask
  task automatic t_buf();
    reset_dut();
    wr(3'h1, 8'h40);
    cfg(`MODE_FAST_FULL, `ACT_CLEAR, `ACT_OFF, 1'b1);
    wait_cnt(8'hFF);
    wait_cnt(8'h10);
    wr(3'h1, 8'h20);
    wait_cnt(8'h30);
    chk({compare_value_a, 1'b0, wave_out_a}, 10'h081);
    wait_cnt(8'h30);
    chk(10'(wave_out_a), 10'h0);
    $display("test buffer done");
  endtask
  task automatic t_sym();
    reset_dut();
    wr(3'h1, 8'h40);
    wr(3'h4, 8'h80);
    cfg(`MODE_PC_FULL, `ACT_SET, `ACT_OFF, 1'b1);
    wait_cnt(8'hFF);
    wait_cnt(8'h80);
    chk(10'(wave_out_a), 10'h1);
    $display("test symmetry done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_n, timer_tick, compare_a_write, compare_b_write, count_write} = 5'h0;
    {force_a, force_b, dir_out, port_level, flag_clear} = 7'h0;
    {mode, act_a, act_b, wdata} = 15'h0;
    err_count = 0;
    check_count = 0;
    cyc(10);
    rst_n <= 1'b1;
    t_hold();
    t_ctc();
    t_late();
    t_block();
    t_force();
    t_duty();
    t_buf();
    t_sym();
    print_verdict();
  end
  // the whole run needs about 100 us; this cuts a hang short
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end
endmodule // timer_waveform_modes_8bit_tb_top
